// ### core/temp_indexed_wiper_control.sv
// temperature-indexed wiper control with two-wire serial register access
// assumes the converter presents a settled temperature and supply result at each frame tick
`include "wiper_params.svh"
`timescale 1ns/100ps
`default_nettype none
module temp_indexed_wiper_control #(
    parameter int FRAME_CYCLES = `FRAME_CYCLES,
    parameter int NV_WRITE_CYCLES = `NV_WRITE_CYCLES,
    parameter int TABLE_DEPTH = `TABLE_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    input wire logic i_addr_select_low,
    input wire logic i_addr_select_high,
    input wire logic [7:0] i_temp_result,
    input wire logic [7:0] i_supply_result,
    output logic [6:0] o_wiper_tap,
    output logic o_nv_busy
);
    localparam int FRAME_W = $clog2(FRAME_CYCLES + 1);
    localparam int NV_W = $clog2(NV_WRITE_CYCLES + 1);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    generate
        // programming time below eight cycles would break the hold check
        if (TABLE_DEPTH != `TABLE_DEPTH || FRAME_CYCLES < 4 || NV_WRITE_CYCLES < 8) begin : g_bad_param
            $error("unsupported table depth or timing count");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // slot of a signed temperature, clamped to the table
    function automatic logic [6:0] slot_of(input logic signed [9:0] t);
        logic signed [9:0] v;
        v = t + `SLOT_TEMP_OFFSET;
        if (v < 10'sh000) begin
            slot_of = 7'h00;
        end else if (v >= `SLOT_TEMP_TOP) begin
            slot_of = 7'h47;
        end else begin
            slot_of = v[7:1];
        end
    endfunction : slot_of

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stages feed only second stages
    logic scl_m_q, scl_s_q, scl_d_q, sda_m_q, sda_s_q, sda_d_q;
    logic a0_m_q, a0_s_q, a1_m_q, a1_s_q;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            {scl_m_q, scl_s_q, scl_d_q, sda_m_q, sda_s_q, sda_d_q} <= 6'h3f;
            {a0_m_q, a0_s_q, a1_m_q, a1_s_q} <= 4'h0;
        end else begin
            {scl_m_q, scl_s_q, scl_d_q} <= {i_scl, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_d_q} <= {i_sda_in, sda_m_q, sda_s_q};
            {a0_m_q, a0_s_q, a1_m_q, a1_s_q} <= {i_addr_select_low, a0_m_q, i_addr_select_high, a1_m_q};
        end
    end
    // edges come from the 125 MHz sampling, ample margin at 400 kHz
    wire scl_rise = scl_s_q & ~scl_d_q;
    wire scl_fall = ~scl_s_q & scl_d_q;
    wire bus_start = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
    wire bus_stop = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;

    ////////////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] ivr_q, cr0_q, cr1_q, cr2_q, idx_q, wiper_q, temp_q, supply_q;
    logic [7:0] lut_q [0:TABLE_DEPTH-1];
    logic nv_busy_q, nv_pend_q, rec_q, first_done_q, tick_q, upd_q;
    logic [NV_W-1:0] nv_cnt_q;
    logic [FRAME_W-1:0] frame_cnt_q;
    logic wr_en_q;
    logic [7:0] wr_addr_q, wr_data_q, ptr_q, shift_q;
    logic [6:0] dev_addr_q;

    wiper_pkg::mode_t mode;
    assign mode = wiper_pkg::mode_t'(cr1_q[1:0]);
    wire update_on = cr1_q[`CR1_UPDATE_BIT];
    wire volatile_only = cr0_q[`CR0_VOLATILE_ONLY_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // table read, additive sum and clamp
    wire [7:0] entry_idx = idx_q - `REG_TABLE_BASE;
    wire [7:0] entry = (entry_idx < 8'(TABLE_DEPTH)) ? lut_q[entry_idx[6:0]] : 8'h00;
    wire signed [8:0] add_sum = $signed({2'b00, ivr_q[6:0]}) + $signed({entry[7], entry});
    wire [6:0] add_clamped = add_sum[8] ? 7'h00 : (add_sum[7] ? 7'h7f : add_sum[6:0]);
    wire [6:0] plain_val = entry[6:0];
    wire [6:0] next_wiper = (mode == wiper_pkg::MODE_ADDITIVE) ? add_clamped : plain_val;

    // slot with one degree of hysteresis
    wire signed [9:0] t_now = {{2{i_temp_result[7]}}, i_temp_result};
    wire [6:0] s_now = slot_of(t_now);
    wire [6:0] s_below = slot_of(t_now - 10'sh001);
    wire [6:0] s_above = slot_of(t_now + 10'sh001);
    wire [6:0] s_cur = entry_idx[6:0];
    wire keep_slot = first_done_q && ((s_now > s_cur && s_below == s_cur) || (s_now < s_cur && s_above == s_cur));
    wire [7:0] next_idx = keep_slot ? idx_q : (`REG_TABLE_BASE + {1'b0, s_now});

    ////////////////////////////////////////////////////////////////////////////////
    // read mux and nonvolatile targets
    wire in_table = (ptr_q >= `REG_TABLE_BASE) && ((ptr_q - `REG_TABLE_BASE) < 8'(TABLE_DEPTH));
    wire [7:0] ptr_slot = ptr_q - `REG_TABLE_BASE;
    wire [7:0] rd_data =
        (ptr_q == `REG_INITIAL_WIPER) ? (volatile_only ? wiper_q : ivr_q) :
        (ptr_q == `REG_CONTROL_ZERO) ? cr0_q :
        (ptr_q == `REG_CONTROL_ONE) ? cr1_q :
        (ptr_q == `REG_TABLE_INDEX) ? idx_q :
        (ptr_q == `REG_WIPER_SETTING) ? wiper_q :
        (ptr_q == `REG_CONTROL_TWO) ? cr2_q :
        (ptr_q == `REG_THERMAL) ? temp_q :
        (ptr_q == `REG_SUPPLY) ? supply_q :
        in_table ? lut_q[ptr_slot[6:0]] : 8'h00;
    wire [7:0] wr_slot = wr_addr_q - `REG_TABLE_BASE;
    wire wr_table = wr_en_q && wr_addr_q >= `REG_TABLE_BASE && wr_slot < 8'(TABLE_DEPTH);
    wire wr_nv = wr_table || (wr_en_q && !volatile_only &&
        (wr_addr_q == `REG_INITIAL_WIPER || wr_addr_q == `REG_CONTROL_ONE));

    ////////////////////////////////////////////////////////////////////////////////
    // frame timer and update pipeline
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            frame_cnt_q <= '0;
            tick_q <= 1'b0;
            upd_q <= 1'b0;
        end else begin
            tick_q <= (frame_cnt_q == FRAME_W'(FRAME_CYCLES - 1));
            frame_cnt_q <= (frame_cnt_q == FRAME_W'(FRAME_CYCLES - 1)) ? '0 : frame_cnt_q + 1'b1;
            upd_q <= tick_q && update_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers and table
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ivr_q <= `RST_INITIAL_WIPER;
            cr0_q <= `RST_CONTROL_ZERO;
            cr1_q <= `RST_CONTROL_ONE;
            cr2_q <= `RST_CONTROL_TWO;
            idx_q <= `RST_TABLE_INDEX;
            wiper_q <= 8'h00;
            temp_q <= 8'h00;
            supply_q <= 8'h00;
            rec_q <= 1'b0;
            first_done_q <= 1'b0;
            for (int i = 0; i < TABLE_DEPTH; i++) begin
                lut_q[i] <= `RST_TABLE_ENTRY;
            end
        end else begin
            rec_q <= 1'b1;
            if (!rec_q) begin
                wiper_q <= {1'b0, ivr_q[6:0]};
            end else if (upd_q) begin
                wiper_q <= {1'b0, next_wiper};
            end
            if (tick_q) begin
                temp_q <= i_temp_result;
                supply_q <= i_supply_result;
                idx_q <= next_idx;
                first_done_q <= 1'b1;
            end
            // host write wins over a frame update in the same cycle
            if (wr_en_q) begin
                case (wr_addr_q)
                    `REG_INITIAL_WIPER: begin
                        wiper_q <= {1'b0, wr_data_q[6:0]};
                        if (!volatile_only) begin
                            ivr_q <= wr_data_q;
                        end
                    end
                    `REG_CONTROL_ZERO: cr0_q <= wr_data_q;
                    `REG_CONTROL_ONE: cr1_q <= wr_data_q;
                    `REG_TABLE_INDEX: idx_q <= wr_data_q;
                    `REG_WIPER_SETTING: wiper_q <= {1'b0, wr_data_q[6:0]};
                    `REG_CONTROL_TWO: cr2_q <= wr_data_q;
                    default: begin
                        if (wr_table) begin
                            lut_q[wr_slot[6:0]] <= wr_data_q;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // nonvolatile programming time, started by the STOP
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            nv_pend_q <= 1'b0;
            nv_busy_q <= 1'b0;
            nv_cnt_q <= '0;
        end else if (bus_stop && (nv_pend_q || wr_nv)) begin
            nv_pend_q <= 1'b0;
            nv_busy_q <= 1'b1;
            nv_cnt_q <= NV_W'(NV_WRITE_CYCLES - 1);
        end else begin
            nv_pend_q <= nv_pend_q | wr_nv;
            if (nv_busy_q) begin
                nv_cnt_q <= nv_cnt_q - 1'b1;
                nv_busy_q <= (nv_cnt_q != '0);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial slave; address ignored while programming
    wiper_pkg::bus_state_t state_q;
    logic [3:0] cnt_q;
    logic addr_ph_q, read_q, ptr_set_q, oe_n_q;
    wire addr_hit = (shift_q[7:1] == dev_addr_q) && !nv_busy_q;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= wiper_pkg::ST_IDLE;
            {cnt_q, shift_q, ptr_q, dev_addr_q} <= 27'h0;
            {addr_ph_q, read_q, ptr_set_q, wr_en_q} <= 4'h0;
            oe_n_q <= 1'b1;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_en_q <= 1'b0;
            if (bus_start) begin
                state_q <= wiper_pkg::ST_RX;
                cnt_q <= 4'h0;
                addr_ph_q <= 1'b1;
                oe_n_q <= 1'b1;
                dev_addr_q <= {`BUS_ADDR_UPPER, a1_s_q, a0_s_q};
            end else if (bus_stop) begin
                state_q <= wiper_pkg::ST_IDLE;
                oe_n_q <= 1'b1;
            end else begin
                case (state_q)
                    wiper_pkg::ST_RX: begin
                        if (scl_rise && cnt_q != 4'h8) begin
                            shift_q <= {shift_q[6:0], sda_s_q};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == 4'h8) begin
                            addr_ph_q <= 1'b0;
                            if (addr_ph_q) begin
                                state_q <= addr_hit ? wiper_pkg::ST_ACK : wiper_pkg::ST_IDLE;
                                oe_n_q <= !addr_hit;
                                read_q <= shift_q[0];
                                ptr_set_q <= 1'b0;
                            end else begin
                                state_q <= wiper_pkg::ST_ACK;
                                oe_n_q <= 1'b0;
                                ptr_set_q <= 1'b1;
                                if (ptr_set_q) begin
                                    wr_en_q <= 1'b1;
                                    wr_addr_q <= ptr_q;
                                    wr_data_q <= shift_q;
                                end
                                ptr_q <= ptr_set_q ? ptr_q + 8'h01 : shift_q;
                            end
                        end
                    end
                    wiper_pkg::ST_ACK: begin
                        if (scl_fall) begin
                            cnt_q <= 4'h0;
                            state_q <= read_q ? wiper_pkg::ST_TX : wiper_pkg::ST_RX;
                            shift_q <= rd_data;
                            oe_n_q <= read_q ? rd_data[7] : 1'b1;
                        end
                    end
                    wiper_pkg::ST_TX: begin
                        if (scl_fall) begin
                            cnt_q <= cnt_q + 4'h1;
                            state_q <= (cnt_q == 4'h7) ? wiper_pkg::ST_TXACK : wiper_pkg::ST_TX;
                            oe_n_q <= (cnt_q == 4'h7) ? 1'b1 : shift_q[6];
                            shift_q <= {shift_q[6:0], 1'b0};
                        end
                    end
                    wiper_pkg::ST_TXACK: begin
                        if (scl_rise) begin
                            state_q <= sda_s_q ? wiper_pkg::ST_IDLE : wiper_pkg::ST_ACK;
                            ptr_q <= sda_s_q ? ptr_q : ptr_q + 8'h01;
                        end
                    end
                    default: state_q <= wiper_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // open drain: only ever pulls low
    logic sda_out_q;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
        end
    end
    assign o_sda_out = sda_out_q;
    assign o_sda_oe_n = oe_n_q;
    assign o_wiper_tap = wiper_q[6:0];
    assign o_nv_busy = nv_busy_q;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    AST_MODE_BITS: assert property (upd_q |-> $past(cr1_q[`CR1_UPDATE_BIT]))
        else $error("wiper update without the update bit");
    AST_ADD_SUM: assert property (upd_q && !wr_en_q && mode == wiper_pkg::MODE_ADDITIVE && !add_sum[8]
        && !add_sum[7] |=> wiper_q[6:0] == $past(ivr_q[6:0]) + $past(entry[6:0]))
        else $error("additive wiper is not initial value plus entry");
    AST_ADD_NEG: assert property (upd_q && !wr_en_q && mode == wiper_pkg::MODE_ADDITIVE && add_sum[8]
        |=> wiper_q == 8'h00)
        else $error("negative sum did not clamp to zero");
    AST_ADD_HIGH: assert property (upd_q && !wr_en_q && mode == wiper_pkg::MODE_ADDITIVE && !add_sum[8]
        && add_sum[7] |=> wiper_q == 8'h7f)
        else $error("large sum did not clamp to 7f");
    AST_WIPER_MSB: assert property (wiper_q[7] == 1'b0)
        else $error("wiper top bit set");
    AST_HOLD_FIRST: assert property (rec_q && !first_done_q && !wr_en_q |=> $stable(wiper_q))
        else $error("wiper moved before first conversion");
    AST_FRAME_UPDATE: assert property (tick_q && update_on |=> upd_q)
        else $error("frame tick gave no wiper update");
    AST_PLAIN: assert property (upd_q && !wr_en_q && mode == wiper_pkg::MODE_PLAIN
        |=> wiper_q == {1'b0, $past(entry[6:0])})
        else $error("plain mode wiper differs from entry");
    AST_COLD_SLOT: assert property (tick_q && !wr_en_q && $signed(i_temp_result) <= -8'sd41
        |=> idx_q == `REG_TABLE_BASE)
        else $error("cold reading did not select the first slot");
    AST_NV_HOLD: assert property ($rose(nv_busy_q) |-> nv_busy_q [*8])
        else $error("programming time ended too early");
    AST_NO_ACK_BUSY: assert property (nv_busy_q && state_q == wiper_pkg::ST_RX && addr_ph_q && scl_fall
        && cnt_q == 4'h8 && !bus_start && !bus_stop |=> state_q == wiper_pkg::ST_IDLE && oe_n_q)
        else $error("address acknowledged while programming");

    COV_PLAIN: cover property (upd_q && mode == wiper_pkg::MODE_PLAIN);
    COV_CLAMP: cover property (upd_q && mode == wiper_pkg::MODE_ADDITIVE && add_sum[7]);
    COV_NV: cover property ($rose(nv_busy_q));
    COV_READ: cover property (state_q == wiper_pkg::ST_TXACK && scl_rise && !sda_s_q);
endmodule : temp_indexed_wiper_control
`default_nettype wire

// ### core/wiper_params.svh
// constants of the temperature-indexed wiper block: offsets, fields, resets, timing
// assumes inclusion by the design module only
`ifndef WIPER_PARAMS_SVH
`define WIPER_PARAMS_SVH
`define REG_INITIAL_WIPER 8'h00
`define REG_CONTROL_ZERO 8'h02
`define REG_CONTROL_ONE 8'h03
`define REG_TABLE_INDEX 8'h08
`define REG_WIPER_SETTING 8'h09
`define REG_CONTROL_TWO 8'h0a
`define REG_THERMAL 8'h0c
`define REG_SUPPLY 8'h0e
`define REG_TABLE_BASE 8'h80
`define CR0_VOLATILE_ONLY_BIT 7
`define CR1_UPDATE_BIT 0
`define CR1_ADD_BIT 1
`define RST_INITIAL_WIPER 8'h00
`define RST_CONTROL_ZERO 8'h00
`define RST_CONTROL_ONE 8'h03
`define RST_CONTROL_TWO 8'h00
`define RST_TABLE_INDEX 8'h00
`define RST_TABLE_ENTRY 8'h00
`define BUS_ADDR_UPPER 5'h0a
`define TABLE_DEPTH 72
`define SLOT_TEMP_OFFSET 10'sh029
`define SLOT_TEMP_TOP 10'sh08f
`define CLK_FREQ_KHZ 125000
`define FRAME_TIME_MS 16
`define NV_WRITE_TIME_MS 10
`define NV_WRITE_MAX_MS 20
`define FRAME_CYCLES (`FRAME_TIME_MS * `CLK_FREQ_KHZ)
`define NV_WRITE_CYCLES (`NV_WRITE_TIME_MS * `CLK_FREQ_KHZ)
`endif

// ### core/wiper_pkg.sv
// types of the temperature-indexed wiper block
// assumes nothing beyond a SystemVerilog compiler
package wiper_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_TXACK = 3'b100
    } bus_state_t;
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_PLAIN = 2'b01,
        MODE_ADD_ONLY = 2'b10,
        MODE_ADDITIVE = 2'b11
    } mode_t;
endpackage : wiper_pkg

// ### sim/bus_host_model.sv
// two-wire bus controller model facing the wiper block's serial port
// assumes the bench resolves the open-drain data wire and returns it on i_sda
`timescale 1ns/100ps
`default_nettype none
module bus_host_model #(
    parameter int QUARTER_NS = 20
) (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    // clock stands high while idle, so no stray edges outside frames
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // waits a quarter first: the device keeps its ack for a few clocks after the fall
    task automatic start_cond();
        #(QUARTER_NS) o_sda = 1'b1;
        #(QUARTER_NS) o_scl = 1'b1;
        #(QUARTER_NS) o_sda = 1'b0;
        #(QUARTER_NS) o_scl = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #(QUARTER_NS) o_sda = 1'b0;
        #(QUARTER_NS) o_scl = 1'b1;
        #(QUARTER_NS) o_sda = 1'b1;
        #(QUARTER_NS);
    endtask : stop_cond
    // eight data bits msb first plus the ack slot; data only moves while clock is low
    task automatic shift9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #(QUARTER_NS) o_sda = tx[i];
            #(QUARTER_NS) o_scl = 1'b1;
            #(2 * QUARTER_NS) rx[i] = i_sda;
            o_scl = 1'b0;
        end
    endtask : shift9
    task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] data, output logic ok);
        logic [8:0] rx;
        start_cond();
        shift9({dev, 1'b0, 1'b1}, rx);
        ok = ~rx[0];
        shift9({ptr, 1'b1}, rx);
        ok = ok & ~rx[0];
        shift9({data, 1'b1}, rx);
        ok = ok & ~rx[0];
        stop_cond();
    endtask : wr_reg
    // pointer set, repeated start, one byte ended by a nack
    task automatic rd_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] data, output logic ok);
        logic [8:0] rx;
        start_cond();
        shift9({dev, 1'b0, 1'b1}, rx);
        ok = ~rx[0];
        shift9({ptr, 1'b1}, rx);
        ok = ok & ~rx[0];
        start_cond();
        shift9({dev, 1'b1, 1'b1}, rx);
        ok = ok & ~rx[0];
        shift9(9'h1ff, rx);
        data = rx[8:1];
        stop_cond();
    endtask : rd_reg
endmodule : bus_host_model
`default_nettype wire

// ### sim/temp_indexed_wiper_control_test.sv
// self-checking bench for the temperature-indexed wiper block
// assumes bus_host_model as bus partner; frame and programming counts are shortened
`timescale 1ns/100ps
`default_nettype none
module temp_indexed_wiper_control_test;
    localparam int FRAME = 64;
    // long enough to outlast a whole refused read issued right after the write
    localparam int NV_CYC = 600;
    localparam logic [7:0] RST_A [11] = '{8'h00, 8'h02, 8'h03, 8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0e, 8'h20, 8'h80, 8'hc7};
    localparam logic [7:0] RST_V [11] = '{8'h00, 8'h00, 8'h03, 8'h80, 8'h00, 8'h00, 8'hd8, 8'h9c, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] ADD_LUT [6] = '{8'h10, 8'hf0, 8'h4f, 8'h60, 8'hd0, 8'h80};
    localparam logic [7:0] ADD_WIP [6] = '{8'h40, 8'h20, 8'h7f, 8'h7f, 8'h00, 8'h00};
    localparam logic [7:0] LUT_A [4] = '{8'h80, 8'h94, 8'h95, 8'hc7};
    localparam logic [7:0] LUT_V [4] = '{8'hc5, 8'h22, 8'hb3, 8'h11};
    localparam logic [7:0] T_IN [9] = '{8'h65, 8'h7f, 8'h00, 8'h01, 8'h02, 8'h01, 8'h00, 8'hff, 8'hd7};
    localparam logic [7:0] T_IDX [9] = '{8'hc7, 8'hc7, 8'h94, 8'h94, 8'h95, 8'h95, 8'h95, 8'h94, 8'h80};
    localparam logic [7:0] T_WIP [9] = '{8'h11, 8'h11, 8'h22, 8'h22, 8'h33, 8'h33, 8'h33, 8'h22, 8'h45};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic a_lo = 1'b0;
    logic a_hi = 1'b0;
    logic [7:0] temp = 8'hd8;
    logic scl, host_sda, sda_out, sda_oe_n, nv_busy, ok;
    logic [6:0] tap;
    logic [7:0] v;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    wire logic sda = host_sda & (sda_oe_n | sda_out);
    wire logic [6:0] dev = {5'b01010, a_hi, a_lo};
    always #4 clk = ~clk;
    temp_indexed_wiper_control #(.FRAME_CYCLES(FRAME), .NV_WRITE_CYCLES(NV_CYC)) dut_u (
        .i_ref_clk(clk), .i_resetn(resetn), .i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out),
        .o_sda_oe_n(sda_oe_n), .i_addr_select_low(a_lo), .i_addr_select_high(a_hi),
        .i_temp_result(temp), .i_supply_result(8'h9c), .o_wiper_tap(tap), .o_nv_busy(nv_busy));
    bus_host_model host_u (.i_sda(sda), .o_scl(scl), .o_sda(host_sda));
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // one ns past the edge so flags have settled
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic get(input logic [7:0] a, input logic [7:0] exp);
        host_u.rd_reg(dev, a, v, ok);
        chk({7'h00, ok}, 8'h01, "read ack");
        chk(v, exp, "read data");
    endtask : get
    // controller side must sit out the programming time before the next access
    task automatic wait_nv(input bit timed);
        int n;
        repeat (40) if (nv_busy !== 1'b1) tick();
        chk({7'h00, nv_busy}, 8'h01, "programming busy");
        n = 0;
        while (nv_busy === 1'b1 && n < NV_CYC + 40) begin
            tick();
            n++;
        end
        chk({7'h00, nv_busy}, 8'h00, "programming end");
        if (timed) chk({7'h00, (n >= NV_CYC - 2 && n <= NV_CYC + 2)}, 8'h01, "programming length");
    endtask : wait_nv
    task automatic put(input logic [7:0] a, input logic [7:0] d, input bit nv);
        host_u.wr_reg(dev, a, d, ok);
        chk({7'h00, ok}, 8'h01, "write ack");
        if (nv) wait_nv(1'b1);
    endtask : put
    // three frames so the slot filter and the wiper have both caught up
    task automatic settle();
        repeat (3 * FRAME) tick();
    endtask : settle
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        #1 resetn = 1'b1;
        chk({1'b0, tap}, 8'h00, "tap after reset");
        settle();
        foreach (RST_A[i]) get(RST_A[i], RST_V[i]);
        for (int p = 0; p < 4; p++) begin
            {a_hi, a_lo} = p[1:0];
            tick();
            host_u.rd_reg(dev ^ 7'h01, 8'h03, v, ok);
            chk({7'h00, ok}, 8'h00, "foreign address ack");
            get(8'h03, 8'h03);
        end
        host_u.wr_reg(dev, 8'h00, 8'h30, ok);
        chk({7'h00, ok}, 8'h01, "initial value write ack");
        host_u.rd_reg(dev, 8'h00, v, ok);
        chk({7'h00, ok}, 8'h00, "ack while programming");
        wait_nv(1'b0);
        get(8'h00, 8'h30);
        foreach (ADD_LUT[i]) begin
            put(8'h80, ADD_LUT[i], 1'b1);
            settle();
            get(8'h09, ADD_WIP[i]);
            chk({1'b0, tap}, ADD_WIP[i], "additive tap");
        end
        put(8'h03, 8'h01, 1'b1);
        get(8'h03, 8'h01);
        foreach (LUT_A[i]) put(LUT_A[i], LUT_V[i], 1'b1);
        foreach (T_IN[i]) begin
            temp = T_IN[i];
            settle();
            get(8'h08, T_IDX[i]);
            get(8'h0c, T_IN[i]);
            chk({1'b0, tap}, T_WIP[i], "plain tap");
        end
        put(8'h03, 8'h00, 1'b1);
        put(8'h09, 8'h5a, 1'b0);
        temp = 8'h65;
        settle();
        chk({1'b0, tap}, 8'h5a, "tap held with updating off");
        put(8'h02, 8'h80, 1'b0);
        put(8'h00, 8'h25, 1'b0);
        repeat (8) tick();
        chk({7'h00, nv_busy}, 8'h00, "volatile write programming");
        chk({1'b0, tap}, 8'h25, "volatile initial value tap");
        get(8'h00, 8'h25);
        put(8'h02, 8'h00, 1'b0);
        get(8'h00, 8'h30);
        wrap_up();
    end
endmodule : temp_indexed_wiper_control_test
`default_nettype wire
